// ===== shared/cryo_pkg.sv
// constants, setting indices, defaults and state codes of the cooling sequencer
// assumes temperatures arrive as signed tenths of a degree on the system clock
`default_nettype none
package cryo_pkg;
  localparam int TEMP_W = 16;
  localparam int SEL_W = 4;
  localparam int SET_COUNT = 11;
  localparam int ALARM_COUNT = 15;
  localparam int TIMER_COUNT = 4;
  // setting indices
  localparam logic [3:0] SEL_MAX_CHAMBER = 4'h0;
  localparam logic [3:0] SEL_CHAMBER_DB = 4'h1;
  localparam logic [3:0] SEL_MIN_COIL = 4'h2;
  localparam logic [3:0] SEL_COIL_DB = 4'h3;
  localparam logic [3:0] SEL_INLET = 4'h4;
  localparam logic [3:0] SEL_STORAGE = 4'h5;
  localparam logic [3:0] SEL_SUPPLY_DLY = 4'h6;
  localparam logic [3:0] SEL_COOL_DLY = 4'h7;
  localparam logic [3:0] SEL_OPEN_DLY = 4'h8;
  localparam logic [3:0] SEL_CLOSED_DLY = 4'h9;
  localparam logic [3:0] SEL_ALARM_EN = 4'ha;
  // reset values: tenths of a degree, minutes for the delays, and a bit mask for the alarm enables
  localparam logic [15:0] DEF_MAX_CHAMBER = 16'hfce0;
  localparam logic [15:0] DEF_CHAMBER_DB = 16'h0064;
  localparam logic [15:0] DEF_MIN_COIL = 16'hfd12;
  localparam logic [15:0] DEF_COIL_DB = 16'h00c8;
  localparam logic [15:0] DEF_INLET = 16'hfd44;
  localparam logic [15:0] DEF_STORAGE = 16'hfce0;
  localparam logic [15:0] DEF_SUPPLY_DLY = 16'h0005;
  localparam logic [15:0] DEF_COOL_DLY = 16'h0078;
  localparam logic [15:0] DEF_OPEN_DLY = 16'h001e;
  localparam logic [15:0] DEF_CLOSED_DLY = 16'h001e;
  localparam logic [15:0] DEF_ALARM_EN = 16'h7fff;
  localparam logic [15:0] SET_RESET [SET_COUNT] = '{DEF_MAX_CHAMBER, DEF_CHAMBER_DB, DEF_MIN_COIL,
    DEF_COIL_DB, DEF_INLET, DEF_STORAGE, DEF_SUPPLY_DLY, DEF_COOL_DLY, DEF_OPEN_DLY, DEF_CLOSED_DLY,
    DEF_ALARM_EN};
  // storage setpoint limits and regulation band
  localparam logic [15:0] STORAGE_LOW = 16'hfa24;
  localparam logic [15:0] STORAGE_HIGH = 16'hfe0c;
  localparam logic [15:0] BAND = 16'h0032;
  // alarm bit positions driven by the sequencer
  localparam int ALM_SUPPLY = 8;
  localparam int ALM_STUCK_OPEN = 9;
  localparam int ALM_STUCK_CLOSED = 10;
  localparam int ALM_COOL_TIME = 12;
  // timer indices
  localparam int TMR_SUPPLY = 0;
  localparam int TMR_COOL = 1;
  localparam int TMR_OPEN = 2;
  localparam int TMR_CLOSED = 3;
  // timing
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3c;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BYPASS = 2'b01,
    ST_COOL = 2'b10,
    ST_PAUSE = 2'b11
  } seq_state_type;
endpackage
`default_nettype wire

// ===== rtl/minute_timer.sv
// elapsed-minutes timer, cleared whenever its run input is low
// assumes a one-cycle tick once per second from the sequencer
`default_nettype none
module minute_timer #(
  parameter int MIN_W = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [MIN_W-1:0] i_limit,
  // status
  output logic o_expired
);
  logic [5:0] sec;
  logic [5:0] next_sec;
  logic [MIN_W-1:0] minutes;
  logic [MIN_W-1:0] next_minutes;
  logic next_expired;

  always_comb begin
    next_sec = sec;
    next_minutes = minutes;
    if (!i_run) begin
      next_sec = 6'h00;
      next_minutes = '0;
    end else if (i_tick) begin
      if (sec == cryo_pkg::SECONDS_PER_MINUTE - 6'h01) begin
        next_sec = 6'h00;
        if (minutes != {MIN_W{1'b1}}) begin
          next_minutes = minutes + 1'b1;
        end
      end else begin
        next_sec = sec + 6'h01;
      end
    end
    next_expired = i_run && (next_minutes >= i_limit);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sec <= 6'h00;
      minutes <= '0;
      o_expired <= 1'b0;
    end else begin
      sec <= next_sec;
      minutes <= next_minutes;
      o_expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cryo_cooling_sequencer.sv
// bypass purge and cooling cycle sequencer with settings, timers and alarms
// assumes temperature words and alarm events come from logic on i_clock; lid switch is a pin
//
// Operation
// - each cooling request starts with bypass until inlet reaches setpoint, then cooling valves
// - chamber above maximum starts bypass purge followed directly by cooling
// - automatic warm-chamber start has no override input at all
// - cold coil outlet closes cooling valves; reopen at minimum plus deadband
// - cycle ends, valves close, when chamber reaches maximum minus chamber deadband
// - reset defaults: -80, 10, -75, 20 and -70 degrees
// - reset defaults: supply delay 5 minutes, cooling time delay 120 minutes
// - reset defaults: stuck open and stuck closed delays 30 minutes each
// - storage setpoint held within -50 to -150; band is plus or minus 5
// - open lid shortens the interval between cooling cycles
// - fifteen status alarms, each enabled or disabled by the user
// - supply delay expiry raises alarm, ends bypass, starts feeding nitrogen
// - inlet not warming after cycle end within delay raises stuck-open alarm
`default_nettype none
module cryo_cooling_sequencer #(
  parameter int TICK_CYCLES = cryo_pkg::TICK_CYCLES,
  parameter int TICK_W = 27
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // temperature readings
  input wire logic [15:0] i_chamber_temp,
  input wire logic [15:0] i_inlet_temp,
  input wire logic [15:0] i_coil_temp,
  input wire logic i_lid_open,
  // settings access
  input wire logic i_set_write,
  input wire logic [3:0] i_set_select,
  input wire logic [15:0] i_set_value,
  input wire logic [3:0] i_read_select,
  output logic [15:0] o_setting_value,
  // alarms
  input wire logic [14:0] i_ext_alarm,
  input wire logic i_alarm_clear,
  output logic [14:0] o_alarm,
  // valves and status
  output logic o_bypass_valve,
  output logic o_cool_valve,
  output logic [1:0] o_state,
  output logic o_in_band
);
  // ****************************************
  // settings
  // ****************************************
  logic [15:0] settings [cryo_pkg::SET_COUNT];
  logic [15:0] next_settings [cryo_pkg::SET_COUNT];
  logic [15:0] next_setting_value;
  logic [15:0] write_value;
  logic written;

  always_comb begin
    write_value = i_set_value;
    if (i_set_select == cryo_pkg::SEL_STORAGE) begin
      if ($signed(i_set_value) < $signed(cryo_pkg::STORAGE_LOW)) begin
        write_value = cryo_pkg::STORAGE_LOW;
      end else if ($signed(i_set_value) > $signed(cryo_pkg::STORAGE_HIGH)) begin
        write_value = cryo_pkg::STORAGE_HIGH;
      end
    end
    for (int k = 0; k < cryo_pkg::SET_COUNT; k++) begin
      next_settings[k] = settings[k];
      if (i_set_write && i_set_select == 4'(k)) begin
        next_settings[k] = write_value;
      end
    end
    next_setting_value = 16'h0000;
    if (i_read_select < 4'(cryo_pkg::SET_COUNT)) begin
      next_setting_value = settings[i_read_select];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      settings <= cryo_pkg::SET_RESET;
      o_setting_value <= 16'h0000;
      written <= 1'b0;
    end else begin
      settings <= next_settings;
      o_setting_value <= next_setting_value;
      written <= written | i_set_write;
    end
  end

  // ****************************************
  // threshold comparisons
  // ****************************************
  logic signed [16:0] chamber;
  logic signed [16:0] inlet;
  logic signed [16:0] coil;
  logic signed [16:0] max_chamber;
  logic signed [16:0] chamber_low;
  logic signed [16:0] lid_start;
  logic signed [16:0] min_coil;
  logic signed [16:0] coil_resume;
  logic signed [16:0] inlet_set;
  logic signed [16:0] band_diff;
  logic lid_meta;
  logic lid_sync;
  logic chamber_warm;
  logic chamber_done;
  logic inlet_cold;
  logic coil_cold;
  logic coil_warm;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lid_meta <= 1'b0;
      lid_sync <= 1'b0;
    end else begin
      lid_meta <= i_lid_open;
      lid_sync <= lid_meta;
    end
  end

  assign chamber = $signed({i_chamber_temp[15], i_chamber_temp});
  assign inlet = $signed({i_inlet_temp[15], i_inlet_temp});
  assign coil = $signed({i_coil_temp[15], i_coil_temp});
  assign max_chamber = $signed({settings[0][15], settings[0]});
  assign chamber_low = max_chamber - $signed({settings[1][15], settings[1]});
  assign lid_start = max_chamber - $signed({{2{settings[1][15]}}, settings[1][15:1]});
  assign min_coil = $signed({settings[2][15], settings[2]});
  assign coil_resume = min_coil + $signed({settings[3][15], settings[3]});
  assign inlet_set = $signed({settings[4][15], settings[4]});
  assign band_diff = chamber - $signed({settings[5][15], settings[5]});
  assign chamber_warm = chamber > (lid_sync ? lid_start : max_chamber);
  assign chamber_done = chamber <= chamber_low;
  assign inlet_cold = inlet <= inlet_set;
  assign coil_cold = coil < min_coil;
  assign coil_warm = coil >= coil_resume;

  // ****************************************
  // second tick and delay timers
  // ****************************************
  logic [TICK_W-1:0] tick_count;
  logic [TICK_W-1:0] next_tick_count;
  logic tick;
  logic [cryo_pkg::TIMER_COUNT-1:0] timer_run;
  logic [cryo_pkg::TIMER_COUNT-1:0] timer_expired;
  logic [15:0] timer_limit [cryo_pkg::TIMER_COUNT];

  assign tick = tick_count == TICK_W'(TICK_CYCLES - 1);
  assign next_tick_count = tick ? '0 : tick_count + 1'b1;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tick_count <= '0;
    end else begin
      tick_count <= next_tick_count;
    end
  end

  assign timer_limit[cryo_pkg::TMR_SUPPLY] = settings[cryo_pkg::SEL_SUPPLY_DLY];
  assign timer_limit[cryo_pkg::TMR_COOL] = settings[cryo_pkg::SEL_COOL_DLY];
  assign timer_limit[cryo_pkg::TMR_OPEN] = settings[cryo_pkg::SEL_OPEN_DLY];
  assign timer_limit[cryo_pkg::TMR_CLOSED] = settings[cryo_pkg::SEL_CLOSED_DLY];

  for (genvar t = 0; t < cryo_pkg::TIMER_COUNT; t++) begin : g_timer
    minute_timer #(.MIN_W(16)) u_timer (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_run(timer_run[t]),
      .i_tick(tick),
      .i_limit(timer_limit[t]),
      .o_expired(timer_expired[t])
    );
  end

  // ****************************************
  // sequencer
  // ****************************************
  cryo_pkg::seq_state_type state;
  cryo_pkg::seq_state_type next_state;
  logic watch_open;
  logic next_watch_open;
  logic next_bypass_valve;
  logic next_cool_valve;
  logic next_in_band;

  always_comb begin
    next_state = state;
    case (state)
      cryo_pkg::ST_IDLE: begin
        if (chamber_warm) begin
          next_state = cryo_pkg::ST_BYPASS;
        end
      end
      cryo_pkg::ST_BYPASS: begin
        if (inlet_cold || timer_expired[cryo_pkg::TMR_SUPPLY]) begin
          next_state = cryo_pkg::ST_COOL;
        end
      end
      cryo_pkg::ST_COOL: begin
        if (chamber_done) begin
          next_state = cryo_pkg::ST_IDLE;
        end else if (coil_cold) begin
          next_state = cryo_pkg::ST_PAUSE;
        end
      end
      cryo_pkg::ST_PAUSE: begin
        if (chamber_done) begin
          next_state = cryo_pkg::ST_IDLE;
        end else if (coil_warm) begin
          next_state = cryo_pkg::ST_COOL;
        end
      end
      default: begin
        next_state = cryo_pkg::ST_IDLE;
      end
    endcase
    next_watch_open = watch_open;
    if (state[1] && next_state == cryo_pkg::ST_IDLE) begin
      next_watch_open = 1'b1;
    end else if (!inlet_cold) begin
      next_watch_open = 1'b0;
    end
    next_bypass_valve = next_state == cryo_pkg::ST_BYPASS;
    next_cool_valve = next_state == cryo_pkg::ST_COOL;
    next_in_band = (band_diff >= -$signed({1'b0, cryo_pkg::BAND})) && (band_diff <= $signed({1'b0, cryo_pkg::BAND}));
    timer_run[cryo_pkg::TMR_SUPPLY] = state == cryo_pkg::ST_BYPASS;
    timer_run[cryo_pkg::TMR_COOL] = state != cryo_pkg::ST_IDLE;
    timer_run[cryo_pkg::TMR_OPEN] = watch_open && state == cryo_pkg::ST_IDLE;
    timer_run[cryo_pkg::TMR_CLOSED] = state == cryo_pkg::ST_COOL && !inlet_cold;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= cryo_pkg::ST_IDLE;
      watch_open <= 1'b0;
      o_bypass_valve <= 1'b0;
      o_cool_valve <= 1'b0;
      o_in_band <= 1'b0;
    end else begin
      state <= next_state;
      watch_open <= next_watch_open;
      o_bypass_valve <= next_bypass_valve;
      o_cool_valve <= next_cool_valve;
      o_in_band <= next_in_band;
    end
  end

  assign o_state = state;

  // ****************************************
  // alarms
  // ****************************************
  logic [14:0] alarm_latch;
  logic [14:0] next_alarm_latch;
  logic [14:0] alarm_event;

  always_comb begin
    alarm_event = i_ext_alarm;
    alarm_event[cryo_pkg::ALM_SUPPLY] = i_ext_alarm[cryo_pkg::ALM_SUPPLY] | timer_expired[cryo_pkg::TMR_SUPPLY];
    alarm_event[cryo_pkg::ALM_COOL_TIME] = i_ext_alarm[cryo_pkg::ALM_COOL_TIME] | timer_expired[cryo_pkg::TMR_COOL];
    alarm_event[cryo_pkg::ALM_STUCK_OPEN] = i_ext_alarm[cryo_pkg::ALM_STUCK_OPEN] | timer_expired[cryo_pkg::TMR_OPEN];
    alarm_event[cryo_pkg::ALM_STUCK_CLOSED] = i_ext_alarm[cryo_pkg::ALM_STUCK_CLOSED] |
      timer_expired[cryo_pkg::TMR_CLOSED];
    // set wins over clear
    next_alarm_latch = (i_alarm_clear ? 15'h0000 : alarm_latch) | alarm_event;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      alarm_latch <= 15'h0000;
    end else begin
      alarm_latch <= next_alarm_latch;
    end
  end

  assign o_alarm = alarm_latch & settings[cryo_pkg::SEL_ALARM_EN][14:0];

  // ****************************************
  // checks
  // ****************************************
  sequence s_bypass_done;
    state == cryo_pkg::ST_BYPASS && inlet_cold;
  endsequence
  sequence s_cool_valves_open;
    !o_bypass_valve && o_cool_valve && state == cryo_pkg::ST_COOL;
  endsequence

  a_bypass_to_cool: assert property (@(posedge i_clock) disable iff (i_rst)
    s_bypass_done |=> s_cool_valves_open) else $error("bypass did not hand over to cooling");
  a_warm_start: assert property (@(posedge i_clock) disable iff (i_rst)
    state == cryo_pkg::ST_IDLE && chamber > max_chamber |=> o_bypass_valve && !o_cool_valve)
    else $error("warm chamber did not start bypass");
  a_coil_pause: assert property (@(posedge i_clock) disable iff (i_rst)
    state == cryo_pkg::ST_COOL && coil_cold && !chamber_done |=> !o_cool_valve ##0 state == cryo_pkg::ST_PAUSE)
    else $error("cold coil did not close cooling valves");
  a_coil_resume: assert property (@(posedge i_clock) disable iff (i_rst)
    state == cryo_pkg::ST_PAUSE && coil_warm && !chamber_done |=> o_cool_valve)
    else $error("warm coil did not reopen cooling valves");
  a_cycle_end: assert property (@(posedge i_clock) disable iff (i_rst)
    state[1] && chamber_done |=> !o_cool_valve && !o_bypass_valve && state == cryo_pkg::ST_IDLE)
    else $error("cycle did not end at lower threshold");
  a_temp_defaults: assert property (@(posedge i_clock) disable iff (i_rst)
    !written |-> settings[0] == 16'hfce0 && settings[1] == 16'h0064 && settings[2] == 16'hfd12 &&
    settings[3] == 16'h00c8 && settings[4] == 16'hfd44) else $error("temperature defaults wrong");
  a_delay_defaults: assert property (@(posedge i_clock) disable iff (i_rst)
    !written |-> settings[6] == 16'h0005 && settings[7] == 16'h0078) else $error("delay defaults wrong");
  a_stuck_defaults: assert property (@(posedge i_clock) disable iff (i_rst)
    !written |-> settings[8] == 16'h001e && settings[9] == 16'h001e) else $error("stuck delay defaults wrong");
  a_storage_range: assert property (@(posedge i_clock) disable iff (i_rst)
    $signed(settings[5]) >= $signed(16'hfa24) && $signed(settings[5]) <= $signed(16'hfe0c))
    else $error("storage setpoint out of range");
  a_lid_early: assert property (@(posedge i_clock) disable iff (i_rst)
    state == cryo_pkg::ST_IDLE && lid_sync && chamber > lid_start |=> state == cryo_pkg::ST_BYPASS)
    else $error("open lid did not start cooling early");
  a_supply_timeout: assert property (@(posedge i_clock) disable iff (i_rst)
    state == cryo_pkg::ST_BYPASS && timer_expired[cryo_pkg::TMR_SUPPLY] |=>
    o_cool_valve && alarm_latch[cryo_pkg::ALM_SUPPLY]) else $error("supply timeout not handled");
  a_stuck_open: assert property (@(posedge i_clock) disable iff (i_rst)
    timer_expired[cryo_pkg::TMR_OPEN] |=> alarm_latch[cryo_pkg::ALM_STUCK_OPEN])
    else $error("stuck open alarm not raised");
endmodule
`default_nettype wire

// ===== rtl/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// ===== tb/cryo_plant_model.sv
// behavioural valves and sensors around the cooling sequencer
// assumes the bench loads readings and a drift rate on i_clock
`default_nettype none
module cryo_plant_model (
  // clock
  input wire logic i_clock,
  // valve drives
  input wire logic i_bypass_valve,
  input wire logic i_cool_valve,
  // bench control
  input wire logic i_load,
  input wire logic [15:0] i_chamber,
  input wire logic [15:0] i_inlet,
  input wire logic [15:0] i_coil,
  input wire logic [15:0] i_rate,
  // sensor readings
  output logic [15:0] o_chamber_temp,
  output logic [15:0] o_inlet_temp,
  output logic [15:0] o_coil_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_chamber_temp = 16'hfc7c;
    o_inlet_temp = 16'hfda8;
    o_coil_temp = 16'hfd44;
  end
  // purge gas cools the inlet, liquid feed cools the chamber
  always @(posedge i_clock) begin
    if (i_load) begin
      o_chamber_temp <= i_chamber;
      o_inlet_temp <= i_inlet;
      o_coil_temp <= i_coil;
    end else begin
      if (i_bypass_valve) o_inlet_temp <= o_inlet_temp - i_rate;
      if (i_cool_valve) o_chamber_temp <= o_chamber_temp - i_rate;
    end
  end
endmodule
`default_nettype wire

// ===== tb/cryo_cooling_sequencer_tb_top.sv
// self-checking bench for the cooling sequencer
// assumes cryo_plant_model and a seconds tick of 2 clocks
`default_nettype none
module cryo_cooling_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_lid_open = 1'b0;
  logic i_set_write = 1'b0;
  logic [3:0] i_set_select = 4'h0;
  logic [15:0] i_set_value = 16'h0000;
  logic [3:0] i_read_select = 4'h0;
  logic [14:0] i_ext_alarm = 15'h0000;
  logic i_alarm_clear = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ld_ch = 16'hfc7c;
  logic [15:0] ld_in = 16'hfda8;
  logic [15:0] ld_co = 16'hfd44;
  logic [15:0] rate = 16'h0000;
  logic [15:0] chamber_temp, inlet_temp, coil_temp, o_setting_value;
  logic [14:0] o_alarm;
  logic o_bypass_valve, o_cool_valve, o_in_band;
  logic [1:0] o_state;
  int fail_count = 0;
  int cmp_count = 0;
  always #4 i_clock = ~i_clock;
  cryo_plant_model u_cryo_plant_model (.i_clock(i_clock), .i_bypass_valve(o_bypass_valve),
    .i_cool_valve(o_cool_valve), .i_load(ld), .i_chamber(ld_ch), .i_inlet(ld_in), .i_coil(ld_co),
    .i_rate(rate), .o_chamber_temp(chamber_temp), .o_inlet_temp(inlet_temp), .o_coil_temp(coil_temp));
  cryo_cooling_sequencer #(.TICK_CYCLES(2)) u_cryo_cooling_sequencer (.i_clock(i_clock), .i_rst(i_rst),
    .i_chamber_temp(chamber_temp), .i_inlet_temp(inlet_temp), .i_coil_temp(coil_temp),
    .i_lid_open(i_lid_open), .i_set_write(i_set_write), .i_set_select(i_set_select),
    .i_set_value(i_set_value), .i_read_select(i_read_select), .o_setting_value(o_setting_value),
    .i_ext_alarm(i_ext_alarm), .i_alarm_clear(i_alarm_clear), .o_alarm(o_alarm),
    .o_bypass_valve(o_bypass_valve), .o_cool_valve(o_cool_valve), .o_state(o_state), .o_in_band(o_in_band));
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic ldt(input logic [15:0] ch, input logic [15:0] inl, input logic [15:0] co, input logic [15:0] r);
    @(posedge i_clock);
    ld <= 1'b1;
    ld_ch <= ch;
    ld_in <= inl;
    ld_co <= co;
    rate <= r;
    @(posedge i_clock);
    ld <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [3:0] sel, input logic [15:0] v);
    @(posedge i_clock);
    i_set_write <= 1'b1;
    i_set_select <= sel;
    i_set_value <= v;
    @(posedge i_clock);
    i_set_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
    @(posedge i_clock);
    i_read_select <= sel;
    step(1);
    check(o_setting_value, exp, "setting");
  endtask
  task automatic wait_state(input logic [1:0] s, input int lim);
    int n;
    n = 0;
    while (o_state !== s && n < lim) begin
      step(1);
      n++;
    end
    check({14'h0, o_state}, {14'h0, s}, "state");
  endtask
  task automatic valves(input logic b, input logic c);
    check({14'h0, o_bypass_valve, o_cool_valve}, {14'h0, b, c}, "valves");
  endtask
  task automatic alarms(input logic [14:0] clr_evt, input logic [14:0] exp);
    @(posedge i_clock);
    i_alarm_clear <= 1'b1;
    i_ext_alarm <= clr_evt;
    @(posedge i_clock);
    i_alarm_clear <= 1'b0;
    i_ext_alarm <= 15'h0000;
    step(2);
    check({1'b0, o_alarm}, {1'b0, exp}, "alarms");
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_defaults();
    logic [15:0] exp [11] = '{16'hfce0, 16'h0064, 16'hfd12, 16'h00c8, 16'hfd44, 16'hfce0, 16'h0005,
      16'h0078, 16'h001e, 16'h001e, 16'h7fff};
    check({1'b0, o_alarm}, 16'h0000, "alarms after reset");
    valves(1'b0, 1'b0);
    for (int i = 0; i < 11; i++) rd(4'(i), exp[i]);
    rd(4'hb, 16'h0000);
    $display("test defaults done");
  endtask
  task automatic t_storage();
    wr(4'h5, 16'hfc18);
    wr(4'hb, 16'h1234);
    rd(4'h5, 16'hfc18);
    rd(4'hb, 16'h0000);
    ldt(16'hfbe6, 16'hfda8, 16'hfd44, 16'h0000);
    step(3);
    check({15'h0, o_in_band}, 16'h0001, "band edge low");
    ldt(16'hfbe5, 16'hfda8, 16'hfd44, 16'h0000);
    step(3);
    check({15'h0, o_in_band}, 16'h0000, "below band");
    ldt(16'hfc4a, 16'hfda8, 16'hfd44, 16'h0000);
    step(3);
    check({15'h0, o_in_band}, 16'h0001, "band edge high");
    wr(4'h5, 16'hf9c0);
    rd(4'h5, 16'hfa24);
    wr(4'h5, 16'hfe70);
    rd(4'h5, 16'hfe0c);
    $display("test storage done");
  endtask
  task automatic t_alarm_mask();
    alarms(15'h0008, 15'h0008);
    wr(4'ha, 16'h7ff7);
    step(1);
    check({1'b0, o_alarm}, 16'h0000, "masked");
    wr(4'ha, 16'h7fff);
    step(1);
    check({1'b0, o_alarm}, 16'h0008, "unmasked");
    alarms(15'h0000, 15'h0000);
    $display("test alarm mask done");
  endtask
  task automatic t_cycle();
    ldt(16'hfce0, 16'hfd4e, 16'hfd44, 16'h0001);
    step(6);
    wait_state(2'b00, 0);
    ldt(16'hfcea, 16'hfd4e, 16'hfd44, 16'h0001);
    wait_state(2'b01, 6);
    valves(1'b1, 1'b0);
    wait_state(2'b10, 30);
    valves(1'b0, 1'b1);
    ldt(16'hfcae, 16'hfd44, 16'hfd11, 16'h0000);
    wait_state(2'b11, 6);
    valves(1'b0, 1'b0);
    ldt(16'hfcae, 16'hfd44, 16'hfdd9, 16'h0000);
    step(6);
    wait_state(2'b11, 0);
    ldt(16'hfcae, 16'hfd44, 16'hfdda, 16'h0000);
    wait_state(2'b10, 6);
    ldt(16'hfc7d, 16'hfd44, 16'hfd44, 16'h0000);
    step(6);
    wait_state(2'b10, 0);
    ldt(16'hfc7c, 16'hfda8, 16'hfd44, 16'h0000);
    wait_state(2'b00, 6);
    valves(1'b0, 1'b0);
    $display("test cycle done");
  endtask
  task automatic t_lid();
    ldt(16'hfcb8, 16'hfda8, 16'hfd44, 16'h0000);
    step(6);
    wait_state(2'b00, 0);
    @(posedge i_clock);
    i_lid_open <= 1'b1;
    wait_state(2'b01, 8);
    alarms(15'h7fff, 15'h7fff);
    wait_state(2'b01, 0);
    ldt(16'hfcb8, 16'hfd44, 16'hfd44, 16'h0000);
    wait_state(2'b10, 6);
    ldt(16'hfc7c, 16'hfda8, 16'hfd44, 16'h0000);
    wait_state(2'b00, 6);
    @(posedge i_clock);
    i_lid_open <= 1'b0;
    alarms(15'h0000, 15'h0000);
    $display("test lid done");
  endtask
  task automatic t_timers();
    wr(4'h6, 16'h0001);
    wr(4'h7, 16'h0003);
    wr(4'h8, 16'h0001);
    wr(4'h9, 16'h0001);
    ldt(16'hfcea, 16'hfda8, 16'hfd44, 16'h0000);
    wait_state(2'b01, 6);
    step(100);
    wait_state(2'b01, 0);
    wait_state(2'b10, 60);
    valves(1'b0, 1'b1);
    step(2);
    check({1'b0, o_alarm}, 16'h0100, "supply alarm");
    // warm inlet while cooling runs the stuck-closed timer
    for (int n = 0; n < 140 && o_alarm[10] !== 1'b1; n++) step(1);
    check({1'b0, o_alarm}, 16'h0500, "stuck closed");
    for (int n = 0; n < 140 && o_alarm[12] !== 1'b1; n++) step(1);
    check({1'b0, o_alarm}, 16'h1500, "cooling time");
    ldt(16'hfc7c, 16'hfce0, 16'hfd44, 16'h0000);
    wait_state(2'b00, 6);
    step(100);
    check({1'b0, o_alarm}, 16'h1500, "stuck open early");
    for (int n = 0; n < 60 && o_alarm[9] !== 1'b1; n++) step(1);
    check({1'b0, o_alarm}, 16'h1700, "stuck open");
    ldt(16'hfc7c, 16'hfda8, 16'hfd44, 16'h0000);
    // let the expired stuck-open timer drop, else its event beats the clear
    step(3);
    alarms(15'h0000, 15'h0000);
    $display("test timers done");
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    step(2);
    t_defaults();
    t_storage();
    t_alarm_mask();
    t_cycle();
    t_lid();
    t_timers();
    finish_test();
  end
  // tests need under 2000 cycles
  initial begin
    #400000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
